// ===== rtl/pm_msi_pkg.sv
// Constants, field layout and carriers for the per-port power-management and
// MSI capability header registers. Assumes a configuration access port
// on the core clock and PME messages arriving from each port's link logic.
// Function
// - The top byte of the status/control word is read-only and shows the entry picked by the selector.
// - The bus power/clock control enable bit and the deep bus state support bit always read as zero.
// - The wake event flag is sticky across ordinary reset; writing one clears it, writing zero keeps it.
// - As a root port the block never sets the wake event flag by itself.
// - With the sticky forward enable set, link PME messages go on to the core; with it clear they are dropped.
// - Each port 1 to 7, function 0, has its own status/control word at bytes 54h to 57h.
// - Byte 58h returns the MSI capability identifier 05h and cannot be written.
// - Byte 59h returns the next pointer 6Ch and cannot be written.
// - To ask for service the block issues a memory write whose address picks the target and data carries the message.
// - The power-management capability header carries next pointer 58h so the MSI capability follows it.
package pm_msi_pkg;

  // Port population
  localparam int NUM_PORTS  = 7;
  localparam int FIRST_PORT = 1;

  // Configuration byte offsets
  localparam logic [7:0] PM_CAP_OFFSET   = 8'h50;
  localparam logic [7:0] PMSC_OFFSET     = 8'h54;
  localparam logic [7:0] MSI_CAP_OFFSET  = 8'h58;
  localparam logic [7:0] MSI_NEXT_OFFSET = 8'h59;

  // Field positions inside the status/control word
  localparam int POWER_STATE_LSB = 0;
  localparam int ENABLE_BIT      = 8;
  localparam int SEL_LSB         = 9;
  localparam int SCALE_LSB       = 13;
  localparam int FLAG_BIT        = 15;
  localparam int DEEP_BIT        = 22;
  localparam int BPCC_BIT        = 23;
  localparam int READOUT_LSB     = 24;

  // Fixed capability values
  localparam logic [7:0] MSI_CAP_ID   = 8'h05;
  localparam logic [7:0] MSI_NEXT_PTR = 8'h6c;
  localparam logic [7:0] PM_CAP_ID    = 8'h01;
  localparam logic [7:0] PM_NEXT_PTR  = 8'h58;
  localparam logic [1:0] SCALE_VALUE  = 2'h0;
  localparam logic       BPCC_VALUE   = 1'b0;
  localparam logic       DEEP_VALUE   = 1'b0;

  // Reset values
  localparam logic [1:0] POWER_STATE_RESET = 2'h0;
  localparam logic [3:0] SEL_RESET         = 4'h0;
  localparam logic       FLAG_RESET        = 1'b0;
  localparam logic       ENABLE_RESET      = 1'b0;

  // Readout byte for each selector value
  localparam logic [15:0][7:0] READOUT_TABLE = {16{8'h00}};

  // One configuration access
  typedef struct packed {
    logic        write;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [5:0]  dword;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  // One MSI memory write
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } msi_write_t;

endpackage

// ===== rtl/wake_msg_forwarder.sv
// One-entry forwarder from a port's link PME message stream to the core.
// Assumes link and core logic on the same clock with valid/ready handshakes.
`timescale 1ns/1ps
module wake_msg_forwarder (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Control
  input  wire logic        forward_enable,
  // Link side
  input  wire logic        link_valid,
  output logic             link_ready,
  input  wire logic [15:0] link_msg,
  // Core side
  output logic             core_valid,
  input  wire logic        core_ready,
  output logic [15:0]      core_msg
);

  logic        full_q;
  logic [15:0] msg_q;
  logic        take;

  // Drain frees the slot in the same cycle
  assign link_ready = !full_q || core_ready;
  assign take       = link_valid && link_ready;
  assign core_valid = full_q;
  assign core_msg   = msg_q;

  // Holding slot; disabled messages are accepted and dropped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      full_q <= 1'b0;
    end else if (take && forward_enable) begin
      full_q <= 1'b1;
    end else if (core_ready) begin
      full_q <= 1'b0;
    end
  end

  // Message payload
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msg_q <= 16'h0000;
    end else if (take && forward_enable) begin
      msg_q <= link_msg;
    end
  end

endmodule // wake_msg_forwarder

// ===== rtl/pcie_port_pm_msi_cap_regs.sv
// Power-management status/control word and MSI capability header, one copy per
// root port 1..7 at function 0, plus PME forwarding and MSI write issue.
// Assumes a configuration access port and a separate sticky (power-good) reset.
`timescale 1ns/1ps
module pcie_port_pm_msi_cap_regs (
  // Clock and resets
  input  wire logic                                   clock,
  input  wire logic                                   resetn,
  input  wire logic                                   sticky_resetn,
  // Configuration access
  input  wire logic                                   cfg_valid,
  input  wire pm_msi_pkg::cfg_req_t                   cfg_req,
  output logic                                        cfg_ack,
  output logic [31:0]                                 cfg_rdata,
  // PME messages from each port's link
  input  wire logic [pm_msi_pkg::NUM_PORTS-1:0]       link_pme_valid,
  output logic [pm_msi_pkg::NUM_PORTS-1:0]            link_pme_ready,
  input  wire logic [pm_msi_pkg::NUM_PORTS-1:0][15:0] link_pme_msg,
  // PME messages to the core
  output logic [pm_msi_pkg::NUM_PORTS-1:0]            core_pme_valid,
  input  wire logic [pm_msi_pkg::NUM_PORTS-1:0]       core_pme_ready,
  output logic [pm_msi_pkg::NUM_PORTS-1:0][15:0]      core_pme_msg,
  // Service requests and their MSI targets
  input  wire logic [pm_msi_pkg::NUM_PORTS-1:0]       svc_request,
  input  wire pm_msi_pkg::msi_write_t [pm_msi_pkg::NUM_PORTS-1:0] svc_target,
  // MSI memory write out
  output logic                                        msi_valid,
  input  wire logic                                   msi_ready,
  output pm_msi_pkg::msi_write_t                      msi_write
);

  localparam int NP = pm_msi_pkg::NUM_PORTS;

  // Per-port state
  logic [NP-1:0][1:0] power_state_q;
  logic [NP-1:0][3:0] sel_q;
  logic [NP-1:0]      flag_q;
  logic [NP-1:0]      enable_q;
  logic [NP-1:0]      port_hit;
  logic [NP-1:0]      pmsc_wr;
  logic [NP-1:0][31:0] pmsc_word;

  // Per-port byte-lane write strobes
  logic [NP-1:0]      low_wr;
  logic [NP-1:0]      ctl_wr;
  logic [NP-1:0]      flag_clr;

  // Access decode shared by all ports
  logic       func_ok;
  logic [7:0] byte_addr;
  logic       is_pm_hdr;
  logic       is_pmsc;
  logic       is_msi_hdr;

  assign func_ok    = (cfg_req.func == 3'h0);
  assign byte_addr  = {cfg_req.dword, 2'b00};
  assign is_pm_hdr  = (byte_addr == pm_msi_pkg::PM_CAP_OFFSET);
  assign is_pmsc    = (byte_addr == pm_msi_pkg::PMSC_OFFSET);
  assign is_msi_hdr = (byte_addr == pm_msi_pkg::MSI_CAP_OFFSET);

  // One register copy and one forwarder per root port
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      // Device number of this port
      assign port_hit[gi] = cfg_valid && func_ok &&
                            (cfg_req.dev == 5'(gi + pm_msi_pkg::FIRST_PORT));
      assign pmsc_wr[gi]  = port_hit[gi] && cfg_req.write && is_pmsc;

      // Lane 0 holds the power state, lane 1 the control and flag bits
      assign low_wr[gi]   = pmsc_wr[gi] && cfg_req.byte_en[0];
      assign ctl_wr[gi]   = pmsc_wr[gi] && cfg_req.byte_en[1];
      assign flag_clr[gi] = ctl_wr[gi] && cfg_req.wdata[pm_msi_pkg::FLAG_BIT];

      // Power state, ordinary reset
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          power_state_q[gi] <= pm_msi_pkg::POWER_STATE_RESET;
        end else if (low_wr[gi]) begin
          power_state_q[gi] <= cfg_req.wdata[pm_msi_pkg::POWER_STATE_LSB +: 2];
        end
      end

      // Readout selector, ordinary reset
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          sel_q[gi] <= pm_msi_pkg::SEL_RESET;
        end else if (ctl_wr[gi]) begin
          sel_q[gi] <= cfg_req.wdata[pm_msi_pkg::SEL_LSB +: 4];
        end
      end

      // Wake event flag: sticky, write-one-to-clear, no hardware set
      always_ff @(posedge clock or negedge sticky_resetn) begin
        if (!sticky_resetn) begin
          flag_q[gi] <= pm_msi_pkg::FLAG_RESET;
        end else if (flag_clr[gi]) begin
          flag_q[gi] <= 1'b0;
        end
      end

      // Forward enable: sticky, software writable
      always_ff @(posedge clock or negedge sticky_resetn) begin
        if (!sticky_resetn) begin
          enable_q[gi] <= pm_msi_pkg::ENABLE_RESET;
        end else if (ctl_wr[gi]) begin
          enable_q[gi] <= cfg_req.wdata[pm_msi_pkg::ENABLE_BIT];
        end
      end

      // Read image of the status/control word
      always_comb begin
        pmsc_word[gi] = 32'h0000_0000;
        pmsc_word[gi][pm_msi_pkg::READOUT_LSB +: 8] =
          pm_msi_pkg::READOUT_TABLE[sel_q[gi]];
        pmsc_word[gi][pm_msi_pkg::BPCC_BIT]  = pm_msi_pkg::BPCC_VALUE;
        pmsc_word[gi][pm_msi_pkg::DEEP_BIT]  = pm_msi_pkg::DEEP_VALUE;
        pmsc_word[gi][pm_msi_pkg::FLAG_BIT]  = flag_q[gi];
        pmsc_word[gi][pm_msi_pkg::SCALE_LSB +: 2] = pm_msi_pkg::SCALE_VALUE;
        pmsc_word[gi][pm_msi_pkg::SEL_LSB +: 4]   = sel_q[gi];
        pmsc_word[gi][pm_msi_pkg::ENABLE_BIT]     = enable_q[gi];
        pmsc_word[gi][pm_msi_pkg::POWER_STATE_LSB +: 2] = power_state_q[gi];
      end

      // Link PME forwarding gated by the enable
      wake_msg_forwarder u_fwd (
        .clock          (clock),
        .resetn         (resetn),
        .forward_enable (enable_q[gi]),
        .link_valid     (link_pme_valid[gi]),
        .link_ready     (link_pme_ready[gi]),
        .link_msg       (link_pme_msg[gi]),
        .core_valid     (core_pme_valid[gi]),
        .core_ready     (core_pme_ready[gi]),
        .core_msg       (core_pme_msg[gi])
      );
    end
  endgenerate

  // Read data selection for the addressed port
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < NP; i++) begin
      if (port_hit[i] && !cfg_req.write) begin
        if (is_pm_hdr) begin
          rdata_d = {16'h0000, pm_msi_pkg::PM_NEXT_PTR, pm_msi_pkg::PM_CAP_ID};
        end else if (is_pmsc) begin
          rdata_d = pmsc_word[i];
        end else if (is_msi_hdr) begin
          rdata_d = {16'h0000, pm_msi_pkg::MSI_NEXT_PTR, pm_msi_pkg::MSI_CAP_ID};
        end
      end
    end
  end

  // Access answer one cycle after every request, mapped or not
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_valid;
    end
  end

  // Read data, zero for writes and unmapped places
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_rdata <= rdata_d;
    end
  end

  // Service request pending bits and lowest-port pick
  logic [NP-1:0] pending_q;
  logic [NP-1:0] grant;
  logic          load;

  // Lowest-numbered pending port wins
  always_comb begin
    grant = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (pending_q[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

  // Output slot empty or draining this cycle
  assign load = (|pending_q) && (!msi_valid || msi_ready);

  // New request wins over the clear of a granted bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pending_q <= '0;
    end else begin
      pending_q <= (pending_q & ~(load ? grant : '0)) | svc_request;
    end
  end

  // MSI write output register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msi_valid <= 1'b0;
    end else if (load) begin
      msi_valid <= 1'b1;
    end else if (msi_ready) begin
      msi_valid <= 1'b0;
    end
  end

  // Target address and message data of the granted port
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msi_write <= '0;
    end else if (load) begin
      for (int i = 0; i < NP; i++) begin
        if (grant[i]) begin
          msi_write <= svc_target[i];
        end
      end
    end
  end

endmodule // pcie_port_pm_msi_cap_regs

// ===== tb/pm_msi_properties.sv
// Checker for the port register bank: config answers, fixed fields,
// PME forwarding cause and MSI write holding.
// Assumes it is bound to the top module, one clock domain.
`timescale 1ns/1ps
module pm_msi_properties (
  // Clock and reset
  input wire logic                              clock,
  input wire logic                              resetn,
  // Config access
  input wire logic                              cfg_valid,
  input wire pm_msi_pkg::cfg_req_t              cfg_req,
  input wire logic                              cfg_ack,
  input wire logic [31:0]                       cfg_rdata,
  // PME and MSI
  input wire logic [pm_msi_pkg::NUM_PORTS-1:0]  link_pme_valid,
  input wire logic [pm_msi_pkg::NUM_PORTS-1:0]  link_pme_ready,
  input wire logic [pm_msi_pkg::NUM_PORTS-1:0]  core_pme_valid,
  input wire logic [pm_msi_pkg::NUM_PORTS-1:0]  core_pme_ready,
  input wire logic [pm_msi_pkg::NUM_PORTS-1:0][15:0] core_pme_msg,
  input wire logic                              msi_valid,
  input wire logic                              msi_ready,
  input wire pm_msi_pkg::msi_write_t            msi_write
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Read of a mapped word in a port's function 0
  sequence rd_at(logic [5:0] dw);
    cfg_valid && !cfg_req.write && cfg_req.func == 3'h0 && cfg_req.dev >= 5'h01 &&
      cfg_req.dev <= 5'h07 && cfg_req.dword == dw;
  endsequence
  a_ack_follows_req: assert property (cfg_valid |=> cfg_ack)
    else $error("config request not answered");
  a_ack_has_cause: assert property (cfg_ack |-> $past(cfg_valid))
    else $error("config answer without request");
  a_upper_zero: assert property (cfg_ack |-> cfg_rdata[23:16] == 8'h00)
    else $error("hardwired or reserved bits not zero");
  a_flag_clear: assert property (cfg_ack |-> !cfg_rdata[15])
    else $error("wake event flag seen set");
  a_readout_byte: assert property (rd_at(6'h15) |=> cfg_rdata[31:24] == 8'h00)
    else $error("readout byte wrong");
  a_msi_header: assert property (rd_at(6'h16) |=> cfg_rdata[15:0] == 16'h6c05)
    else $error("msi header wrong");
  a_pm_header: assert property (rd_at(6'h14) |=> cfg_rdata[15:0] == 16'h5801)
    else $error("pm header wrong");
  a_fwd_cause: assert property ($rose(core_pme_valid[0]) |->
    $past(link_pme_valid[0] && link_pme_ready[0]))
    else $error("core message without link message");
  // Core side stalled while a message is held
  sequence core_stall;
    core_pme_valid[0] && !core_pme_ready[0];
  endsequence
  a_core_hold: assert property (core_stall |=>
    core_pme_valid[0] && $stable(core_pme_msg[0]))
    else $error("held core message dropped or changed");
  a_link_refused: assert property (core_stall |-> !link_pme_ready[0])
    else $error("link message taken into a full slot");
  a_msi_hold: assert property (msi_valid && !msi_ready |=> msi_valid && $stable(msi_write))
    else $error("msi write dropped or changed");
endmodule // pm_msi_properties

// ===== tb/pme_link_model.sv
// Link-side PME sender for all seven ports.
// Assumes one caller of send() per port at a time.
`timescale 1ns/1ps
module pme_link_model (
  // Clock
  input  wire logic             clock,
  // Link stream
  input  wire logic [6:0]       ready,
  output logic      [6:0]       valid,
  output logic      [6:0][15:0] msg
);
  int stalls;
  initial begin
    valid = '0;
    msg = '0;
    stalls = 0;
  end
  // Offer one message and hold it until taken, for at most 64 cycles
  task automatic send(input int p, input logic [15:0] m);
    int n;
    @(negedge clock);
    valid[p] = 1'b1;
    msg[p] = m;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!ready[p] && n < 64);
    if (!ready[p]) stalls++;  // Never taken: counts as a mismatch
    @(negedge clock);
    valid[p] = 1'b0;
    msg[p] = ~m;  // Released line shows no stale value
  endtask
endmodule // pme_link_model

// ===== tb/testbench.sv
// Self-checking bench for the port register bank.
// Assumes the design, its package and the link model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic                                clock = 1'b0;
  logic                                resetn = 1'b0;
  logic                                sticky_resetn = 1'b0;
  logic                                cfg_valid = 1'b0;
  pm_msi_pkg::cfg_req_t                cfg_req = '0;
  logic                                cfg_ack;
  logic [31:0]                         cfg_rdata;
  logic [6:0]                          lv, lr, cv;
  logic [6:0]                          svc_request = '0;
  logic [6:0]                          core_pme_ready = '1;
  logic [6:0][15:0]                    lm, cm;
  pm_msi_pkg::msi_write_t [6:0]        svc_target = '0;
  pm_msi_pkg::msi_write_t              msi_write;
  logic                                msi_valid;
  logic                                msi_ready = 1'b1;
  logic [31:0]                         pm [7];
  logic [63:0]                         cq[$], pq[$], mq[$];
  int                                  err_count = 0, check_count = 0, seed = 32'he2c1b4ae;

  always #2.5 clock = ~clock;
  pme_link_model i_link (.clock(clock), .ready(lr), .valid(lv), .msg(lm));
  pcie_port_pm_msi_cap_regs i_dut (.clock(clock), .resetn(resetn),
    .sticky_resetn(sticky_resetn), .cfg_valid(cfg_valid), .cfg_req(cfg_req),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .link_pme_valid(lv), .link_pme_ready(lr),
    .link_pme_msg(lm), .core_pme_valid(cv), .core_pme_ready(core_pme_ready),
    .core_pme_msg(cm), .svc_request(svc_request), .svc_target(svc_target),
    .msi_valid(msi_valid), .msi_ready(msi_ready), .msi_write(msi_write));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    err_count += i_link.stalls;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One config access at a falling edge; notes the expected answer
  task automatic cfg(input logic w, input int d, input int f, input logic [5:0] dw,
                     input logic [3:0] be, input logic [31:0] wd);
    logic ok;
    ok = f == 0 && d >= 1 && d <= 7 && dw == 6'h15;
    @(negedge clock);
    cfg_valid = 1'b1;
    cfg_req = '{w, d[4:0], f[2:0], dw, be, wd};
    if (w && ok && be[0]) pm[d-1][1:0] = wd[1:0];
    if (w && ok && be[1]) pm[d-1][12:8] = wd[12:8];
    if (w || f != 0 || d < 1 || d > 7) cq.push_back(0);
    else case (dw)
      6'h14: cq.push_back(32'h0000_5801);
      6'h15: cq.push_back({pm_msi_pkg::READOUT_TABLE[pm[d-1][12:9]], pm[d-1][23:0]});
      6'h16: cq.push_back(32'h0000_6c05);
      default: cq.push_back(0);
    endcase
  endtask
  // Ends strobes and waits, bounded, for every note to be met
  task automatic drain(input string name);
    int n;
    @(negedge clock);
    cfg_valid = 1'b0;
    svc_request = '0;
    n = 0;
    while (cq.size() + pq.size() + mq.size() > 0 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n == 200) begin
      err_count++;
      stop_test();
    end
    $display("test %s done", name);
  endtask

  // Far-side stalls
  always @(negedge clock) begin
    core_pme_ready <= 7'($random(seed));
    msi_ready <= 1'($random(seed));
  end
  // Compares each result with the oldest note
  always @(posedge clock) begin
    if (resetn && cfg_ack) check(cfg_rdata, cq.size() ? cq.pop_front() : ~cfg_rdata);
    for (int p = 0; p < 7; p++)
      if (resetn && cv[p] && core_pme_ready[p])
        check({p[3:0], cm[p]}, pq.size() ? pq.pop_front() : 64'hffff_ffff);
    if (resetn && msi_valid && msi_ready)
      check(msi_write, mq.size() ? mq.pop_front() : ~msi_write);
  end

  initial begin
    logic [31:0] wd;
    for (int i = 0; i < 7; i++) pm[i] = 0;
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    sticky_resetn = 1'b1;
    // Reset values, headers and unmapped places, back to back
    for (int d = 0; d <= 8; d++)
      for (int dw = 'h13; dw <= 'h17; dw++) cfg(0, d, 0, dw[5:0], 4'hf, 0);
    cfg(0, 1, 1, 6'h15, 4'hf, 0);
    cfg(1, 2, 0, 6'h16, 4'hf, 32'hffff_ffff);
    drain("reset values");
    // Every selector with random other bits, then a low-byte-only write
    for (int s = 0; s < 16; s++) begin
      wd = $random(seed);
      wd[12:9] = s[3:0];
      cfg(1, 2, 0, 6'h15, 4'hf, wd);
      cfg(0, 2, 0, 6'h15, 4'hf, 0);
    end
    cfg(1, 2, 0, 6'h15, 4'h1, 32'hffff_ffff);
    cfg(0, 2, 0, 6'h15, 4'hf, 0);
    cfg(1, 1, 0, 6'h15, 4'h3, 32'h0000_8103);
    cfg(1, 2, 0, 6'h15, 4'h2, 0);
    cfg(0, 2, 0, 6'h16, 4'hf, 0);
    drain("fields");
    // Ordinary reset keeps only the sticky bits
    resetn = 1'b0;
    for (int i = 0; i < 7; i++) pm[i] &= 32'h0000_8100;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    cfg(0, 1, 0, 6'h15, 4'hf, 0);
    cfg(0, 2, 0, 6'h15, 4'hf, 0);
    drain("sticky");
    // Enabled port forwards, disabled port drops
    for (int k = 0; k < 6; k++) begin
      wd = $random(seed);
      pq.push_back({4'h0, wd[15:0]});
      i_link.send(0, wd[15:0]);
    end
    i_link.send(1, 16'h1234);
    drain("pme forwarding");
    // Three service requests at once, lowest port first
    @(negedge clock);
    for (int i = 0; i < 7; i++) svc_target[i] = {$random(seed), $random(seed)};
    svc_request = 7'h49;
    mq.push_back(svc_target[0]);
    mq.push_back(svc_target[3]);
    mq.push_back(svc_target[6]);
    drain("msi writes");
    stop_test();
  end
endmodule // testbench

bind pcie_port_pm_msi_cap_regs pm_msi_properties i_props (.clock(clock), .resetn(resetn),
  .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
  .link_pme_valid(link_pme_valid), .link_pme_ready(link_pme_ready),
  .core_pme_valid(core_pme_valid), .core_pme_ready(core_pme_ready),
  .core_pme_msg(core_pme_msg), .msi_valid(msi_valid), .msi_ready(msi_ready),
  .msi_write(msi_write));
